/* File: src/ttx_window_pkg.sv */
// Constants for the teletext request window and active line logic.
package ttx_window_pkg;

	// ==========================================================
	// Register subaddresses.
	localparam logic [7:0] ADDR_ODD_START = 8'h76;
	localparam logic [7:0] ADDR_ODD_END = 8'h77;
	localparam logic [7:0] ADDR_EVEN_START = 8'h78;
	localparam logic [7:0] ADDR_EVEN_END = 8'h79;
	localparam logic [7:0] ADDR_FIRST_ACTIVE = 8'h7A;
	localparam logic [7:0] ADDR_LAST_ACTIVE = 8'h7B;
	localparam logic [7:0] ADDR_MODE_MSBS = 8'h7C;

	// ==========================================================
	// Field positions in the mode and line MSB register.
	localparam int BIT_STANDARD = 7;
	localparam int BIT_LAST_ACTIVE_MSB = 6;
	localparam int BIT_PROTOCOL = 5;
	localparam int BIT_FIRST_ACTIVE_MSB = 4;
	localparam int BIT_EVEN_END_MSB = 3;
	localparam int BIT_ODD_END_MSB = 2;
	localparam int BIT_EVEN_START_MSB = 1;
	localparam int BIT_ODD_START_MSB = 0;

	// ==========================================================
	// Reset values; start and end line values chosen by the video standard strap.
	localparam logic [7:0] RST_ODD_START_PAL = 8'h05;
	localparam logic [7:0] RST_ODD_START_NTSC = 8'h06;
	localparam logic [7:0] RST_EVEN_START_PAL = 8'h04;
	localparam logic [7:0] RST_EVEN_START_NTSC = 8'h05;
	localparam logic [7:0] RST_END_PAL = 8'h16;
	localparam logic [7:0] RST_END_NTSC = 8'h10;
	localparam logic [7:0] RST_ACTIVE_LINE = 8'h00;
	localparam logic [7:0] RST_MODE_MSBS = 8'h00;

	// ==========================================================
	// Line offsets added to programmed values.
	localparam logic [9:0] START_ADJ_M = 10'h004;
	localparam logic [9:0] START_ADJ_OTHER = 10'h001;
	localparam logic [9:0] END_ADJ_M = 10'h003;
	localparam logic [9:0] END_ADJ_OTHER = 10'h000;

	// ==========================================================
	// Teletext standards and request window lengths in bit slots.
	typedef enum logic [1:0] {
		STD_EUROPEAN,
		STD_NABTS,
		STD_WORLD_60HZ
	} teletext_standard_e;
	localparam logic [9:0] BITS_EUROPEAN = 10'h168;
	localparam logic [9:0] BITS_NABTS = 10'h120;
	localparam logic [9:0] BITS_WORLD_60HZ = 10'h128;

endpackage

/* File: src/ttx_window.sv */
// Teletext request window, active line window and teletext bit FIFO.
//
// Behaviour
// - Odd end line: value plus 3 or 0.
// - Even start line: value plus 4 or 1.
// - Even end line: value plus 3 or 0.
// - First active line: value plus 4 or 1.
// - Last active line: value plus 3 or 0.
// - Line zero is first field sync line.
// - Ninth bits come from register 7Ch.
// - Bit 7 and field rate pick standard.
// - Protocol 0: one rising edge per bit.
// - Protocol 1: request held high per line.
// - Pin carries request only when aux deselected.
// - Odd start line: value plus 4 or 1.
`timescale 1ns/10ps

// ==========================================================
// Synchronous FIFO with valid and ready on both sides.
module ttx_bit_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} fifo_s;

	fifo_s s_q;
	fifo_s s_d;
	logic push;
	logic pop;

	always_comb begin
		s_d = s_q;
		push = i_in_valid && (s_q.count != (AW+1)'(DEPTH));
		pop = i_out_ready && (s_q.count != '0);
		if (push) begin
			s_d.mem[s_q.wr] = i_in_data;
			s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
		end
		if (push && !pop) begin
			s_d.count = s_q.count + 1'b1;
		end else if (pop && !push) begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_in_ready = (s_q.count != (AW+1)'(DEPTH));
	assign o_out_valid = (s_q.count != '0);
	assign o_out_data = s_q.mem[s_q.rd];
endmodule

// ==========================================================
// Vertical window logic with register file and request generation.
module ttx_window #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_strap_ntsc,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_write,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_read,
	output logic [7:0] o_reg_rdata,
	input wire logic i_m_system,
	input wire logic i_field_rate_select,
	input wire logic i_aux_clock_output_select,
	input wire logic i_aux_clock,
	input wire logic i_field_sync,
	input wire logic i_odd_field,
	input wire logic i_line_start,
	input wire logic i_bit_slot,
	input wire logic i_ttx_valid,
	input wire logic i_ttx_bit,
	output logic o_ttx_ready,
	input wire logic i_out_ready,
	output logic o_out_valid,
	output logic o_out_bit,
	output logic o_teletext_request,
	output logic o_request_or_aux_clock_pin,
	output logic o_active_line,
	output logic [1:0] o_teletext_standard
);
	typedef struct packed {
		logic [7:0] odd_start;
		logic [7:0] odd_end;
		logic [7:0] even_start;
		logic [7:0] even_end;
		logic [7:0] first_active;
		logic [7:0] last_active;
		logic [7:0] mode_msbs;
		logic [7:0] rdata;
		logic [8:0] line;
		logic [9:0] slots;
		logic request;
		logic pin;
		logic active;
		logic [1:0] standard;
		logic ttx_ready;
		logic out_valid;
		logic out_bit;
	} window_s;

	window_s s_q;
	window_s s_d;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_bit;
	logic [9:0] start_adj;
	logic [9:0] end_adj;
	logic [9:0] line_start_val;
	logic [9:0] line_end_val;
	logic [9:0] active_first;
	logic [9:0] active_last;
	logic [9:0] cur_line;
	logic [9:0] window_bits;
	logic in_window;
	ttx_window_pkg::teletext_standard_e standard;

	// Bits arrive one per request; the FIFO absorbs them until the modulator drains.
	ttx_bit_fifo #(
		.WIDTH(1),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_in_valid(i_ttx_valid),
		.o_in_ready(fifo_in_ready),
		.i_in_data(i_ttx_bit),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(i_out_ready),
		.o_out_data(fifo_out_bit)
	);

	always_comb begin
		s_d = s_q;
		start_adj = i_m_system ? ttx_window_pkg::START_ADJ_M : ttx_window_pkg::START_ADJ_OTHER;
		end_adj = i_m_system ? ttx_window_pkg::END_ADJ_M : ttx_window_pkg::END_ADJ_OTHER;
		cur_line = {1'b0, s_q.line};

		// The ninth bit of each line value sits in the shared MSB register.
		if (i_odd_field) begin
			line_start_val = {1'b0, s_q.mode_msbs[ttx_window_pkg::BIT_ODD_START_MSB], s_q.odd_start}
				+ start_adj;
			line_end_val = {1'b0, s_q.mode_msbs[ttx_window_pkg::BIT_ODD_END_MSB], s_q.odd_end}
				+ end_adj;
		end else begin
			line_start_val = {1'b0, s_q.mode_msbs[ttx_window_pkg::BIT_EVEN_START_MSB], s_q.even_start}
				+ start_adj;
			line_end_val = {1'b0, s_q.mode_msbs[ttx_window_pkg::BIT_EVEN_END_MSB], s_q.even_end}
				+ end_adj;
		end
		active_first = {1'b0, s_q.mode_msbs[ttx_window_pkg::BIT_FIRST_ACTIVE_MSB], s_q.first_active}
			+ start_adj;
		active_last = {1'b0, s_q.mode_msbs[ttx_window_pkg::BIT_LAST_ACTIVE_MSB], s_q.last_active}
			+ end_adj;
		in_window = (cur_line >= line_start_val) && (cur_line <= line_end_val);

		// World standard 60 Hz teletext is only meaningful at the 60 Hz field rate.
		if (s_q.mode_msbs[ttx_window_pkg::BIT_STANDARD] && i_field_rate_select) begin
			standard = ttx_window_pkg::STD_WORLD_60HZ;
			window_bits = ttx_window_pkg::BITS_WORLD_60HZ;
		end else if (i_field_rate_select) begin
			standard = ttx_window_pkg::STD_NABTS;
			window_bits = ttx_window_pkg::BITS_NABTS;
		end else begin
			standard = ttx_window_pkg::STD_EUROPEAN;
			window_bits = ttx_window_pkg::BITS_EUROPEAN;
		end
		s_d.standard = standard;

		// Register writes.
		if (i_reg_write) begin
			unique case (i_reg_addr)
				ttx_window_pkg::ADDR_ODD_START: s_d.odd_start = i_reg_wdata;
				ttx_window_pkg::ADDR_ODD_END: s_d.odd_end = i_reg_wdata;
				ttx_window_pkg::ADDR_EVEN_START: s_d.even_start = i_reg_wdata;
				ttx_window_pkg::ADDR_EVEN_END: s_d.even_end = i_reg_wdata;
				ttx_window_pkg::ADDR_FIRST_ACTIVE: s_d.first_active = i_reg_wdata;
				ttx_window_pkg::ADDR_LAST_ACTIVE: s_d.last_active = i_reg_wdata;
				ttx_window_pkg::ADDR_MODE_MSBS: s_d.mode_msbs = i_reg_wdata;
				default: ;
			endcase
		end

		// Register reads; unmapped subaddresses read zero.
		if (i_reg_read) begin
			unique case (i_reg_addr)
				ttx_window_pkg::ADDR_ODD_START: s_d.rdata = s_q.odd_start;
				ttx_window_pkg::ADDR_ODD_END: s_d.rdata = s_q.odd_end;
				ttx_window_pkg::ADDR_EVEN_START: s_d.rdata = s_q.even_start;
				ttx_window_pkg::ADDR_EVEN_END: s_d.rdata = s_q.even_end;
				ttx_window_pkg::ADDR_FIRST_ACTIVE: s_d.rdata = s_q.first_active;
				ttx_window_pkg::ADDR_LAST_ACTIVE: s_d.rdata = s_q.last_active;
				ttx_window_pkg::ADDR_MODE_MSBS: s_d.rdata = s_q.mode_msbs;
				default: s_d.rdata = 8'h00;
			endcase
		end

		// Line zero is the line of the first field sync pulse.
		if (i_field_sync) begin
			s_d.line = 9'h000;
			s_d.slots = 10'h000;
		end else if (i_line_start) begin
			s_d.line = (s_q.line == 9'h1FF) ? s_q.line : s_q.line + 9'h001;
			s_d.slots = 10'h000;
		end

		s_d.active = (cur_line >= active_first) && (cur_line <= active_last);

		// A full FIFO withholds requests, so the source is never asked for a bit it cannot land.
		s_d.request = 1'b0;
		if (in_window && fifo_in_ready) begin
			if (s_q.mode_msbs[ttx_window_pkg::BIT_PROTOCOL]) begin
				// Held high for a standard-dependent number of bit slots per line.
				s_d.request = (s_q.slots < window_bits);
				if (i_bit_slot && (s_q.slots < window_bits)) begin
					s_d.slots = s_q.slots + 10'h001;
				end
			end else begin
				// One cycle high per slot gives exactly one rising edge per bit.
				s_d.request = i_bit_slot;
			end
		end

		s_d.pin = i_aux_clock_output_select ? i_aux_clock : s_d.request;
		s_d.ttx_ready = fifo_in_ready;
		s_d.out_valid = fifo_out_valid;
		s_d.out_bit = fifo_out_bit;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s_q <= '0;
			s_q.odd_start <= i_strap_ntsc ? ttx_window_pkg::RST_ODD_START_NTSC : ttx_window_pkg::RST_ODD_START_PAL;
			s_q.odd_end <= i_strap_ntsc ? ttx_window_pkg::RST_END_NTSC : ttx_window_pkg::RST_END_PAL;
			s_q.even_start <= i_strap_ntsc ? ttx_window_pkg::RST_EVEN_START_NTSC
				: ttx_window_pkg::RST_EVEN_START_PAL;
			s_q.even_end <= i_strap_ntsc ? ttx_window_pkg::RST_END_NTSC : ttx_window_pkg::RST_END_PAL;
			s_q.first_active <= ttx_window_pkg::RST_ACTIVE_LINE;
			s_q.last_active <= ttx_window_pkg::RST_ACTIVE_LINE;
			s_q.mode_msbs <= ttx_window_pkg::RST_MODE_MSBS;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_reg_rdata = s_q.rdata;
	assign o_teletext_request = s_q.request;
	assign o_request_or_aux_clock_pin = s_q.pin;
	assign o_active_line = s_q.active;
	assign o_teletext_standard = s_q.standard;
	assign o_ttx_ready = s_q.ttx_ready;
	assign o_out_valid = s_q.out_valid;
	assign o_out_bit = s_q.out_bit;
endmodule

/* File: tb/ttx_window_props.sv */
// Port checks for the teletext window block.
`timescale 1ns/10ps
// ====
// Checker
module ttx_window_props (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_write,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_read,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_field_rate_select,
	input wire logic i_aux_clock_output_select,
	input wire logic i_aux_clock,
	input wire logic i_bit_slot,
	input wire logic o_teletext_request,
	input wire logic o_request_or_aux_clock_pin,
	input wire logic [1:0] o_teletext_standard
);
	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic [1:0] std_d;
	always_comb begin
		mode_d = (i_reg_write && i_reg_addr == 8'h7C) ? i_reg_wdata : mode_q;
		std_d = (mode_q[7] && i_field_rate_select) ? 2'h2 : {1'b0, i_field_rate_select};
	end
	// Shadow of the mode register, so protocol and standard are known from the ports alone.
	always_ff @(posedge i_clk) begin
		mode_q <= i_reset ? 8'h00 : mode_d;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	chk_pin_request: assert property (!$past(i_reset) && !$past(i_aux_clock_output_select)
		|-> o_request_or_aux_clock_pin == o_teletext_request) else $error("pin not request");
	chk_pin_aux: assert property (!$past(i_reset) && $past(i_aux_clock_output_select)
		|-> o_request_or_aux_clock_pin == $past(i_aux_clock)) else $error("pin not aux clock");
	chk_pulse_cause: assert property (!mode_q[5] && $rose(o_teletext_request)
		|-> $past(i_bit_slot)) else $error("request without slot");
	chk_pulse_width: assert property (!mode_q[5] && o_teletext_request
		|=> !o_teletext_request) else $error("request pulse too long");
	chk_std_select: assert property ($stable({mode_q[7], i_field_rate_select})[*3]
		|-> o_teletext_standard == std_d) else $error("wrong standard");
	chk_unmapped_zero: assert property ($past(i_reg_read) && ($past(i_reg_addr) < 8'h76
		|| $past(i_reg_addr) > 8'h7C) |-> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!$past(i_reset) && !$past(i_reg_read)
		|-> $stable(o_reg_rdata)) else $error("read data moved");
	chk_write_read: assert property (i_reg_write && i_reg_addr == 8'h7C ##1 i_reg_read && i_reg_addr == 8'h7C
		|=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("mode readback wrong");
endmodule

bind ttx_window ttx_window_props ttx_window_props_inst (.i_clk, .i_reset, .i_reg_addr, .i_reg_write,
	.i_reg_wdata, .i_reg_read, .o_reg_rdata, .i_field_rate_select, .i_aux_clock_output_select, .i_aux_clock,
	.i_bit_slot, .o_teletext_request, .o_request_or_aux_clock_pin, .o_teletext_standard);

/* File: tb/ttx_source_model.sv */
// Behavioural teletext bit source.
`timescale 1ns/10ps
// ====
// Source
module ttx_source_model (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_request,
	input wire logic i_ready,
	output logic o_valid,
	output logic o_bit
);
	logic seen_q;
	logic [15:0] sent;
	initial begin
		o_valid = 1'b0;
		o_bit = 1'b1;
		seen_q = 1'b0;
		sent = 16'h0000;
	end
	// One bit per rising request edge; between bits the line shows the inverse of the last one.
	always @(posedge i_clk) begin
		if (i_request && !seen_q && !i_reset) begin
			#1 o_valid = 1'b1;
			o_bit = sent[0];
			do @(posedge i_clk); while (!i_ready);
			sent = sent + 16'h0001;
			#1 o_valid = 1'b0;
			o_bit = !o_bit;
		end
		seen_q = i_request;
	end
endmodule

/* File: tb/ttx_window_bench.sv */
// Self-checking bench for the teletext window block.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
// ====
// Bench
module ttx_window_bench;
	logic i_clk, i_reset, i_strap_ntsc, i_reg_write, i_reg_read, i_m_system, i_field_rate_select, i_aux_clock;
	logic i_aux_clock_output_select, i_field_sync, i_odd_field, i_line_start, i_bit_slot, i_ttx_valid, i_ttx_bit;
	logic o_ttx_ready, i_out_ready, o_out_valid, o_teletext_request, o_request_or_aux_clock_pin, eol, rd_q, req_q;
	logic o_out_bit;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, v, ev;
	logic [1:0] o_teletext_standard;
	logic [3:0] cnt, ec;
	logic [16:0] r;
	logic [7:0] q_rd[$];
	logic [3:0] q_req[$];
	logic [7:0] rv [2][8] = '{'{8'h05, 8'h16, 8'h04, 8'h16, 8'h00, 8'h00, 8'h00, 8'h00},
		'{8'h06, 8'h10, 8'h05, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00}};
	int num_errors, cmp_count;
	ttx_window ttx_window_inst (.i_clk, .i_reset, .i_strap_ntsc, .i_reg_addr, .i_reg_write, .i_reg_wdata, .i_reg_read,
		.o_reg_rdata, .i_m_system, .i_field_rate_select, .i_aux_clock_output_select, .i_aux_clock, .i_field_sync,
		.i_odd_field, .i_line_start, .i_bit_slot, .i_ttx_valid, .i_ttx_bit, .o_ttx_ready, .i_out_ready,
		.o_out_valid, .o_out_bit, .o_teletext_request, .o_request_or_aux_clock_pin, .o_active_line(),
		.o_teletext_standard);
	ttx_source_model ttx_source_model_inst (.i_clk, .i_reset, .i_request(o_teletext_request),
		.i_ready(o_ttx_ready), .o_valid(i_ttx_valid), .o_bit(i_ttx_bit));
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	task automatic xfer(input logic w, input logic rd, input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk) #1;
		{i_reg_write, i_reg_read, i_reg_addr, i_reg_wdata} = {w, rd, a, d};
		if (rd) q_rd.push_back(d);
	endtask
	task automatic do_reset(input logic s);
		i_strap_ntsc = s;
		i_reset = 1'b1;
		repeat (4) @(posedge i_clk);
		#1 i_reset = 1'b0;
	endtask
	task automatic line(input logic sync, input int n, input logic [3:0] e, input logic chk);
		@(posedge i_clk) #1 {i_field_sync, i_line_start} = {sync, !sync};
		@(posedge i_clk) #1 {i_field_sync, i_line_start} = 2'h0;
		repeat (n) begin
			repeat (3) @(posedge i_clk);
			#1 i_bit_slot = 1'b1;
			@(posedge i_clk) #1 i_bit_slot = 1'b0;
		end
		repeat (4) @(posedge i_clk);
		if (chk) q_req.push_back(e);
		#1 eol = chk;
		@(posedge i_clk) #1 eol = 1'b0;
	endtask
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	initial begin
		#100000;
		num_errors++;
		summarize();
	end
	always @(posedge i_clk) begin
		#1 r = lfsr(r);
		i_aux_clock = r[0];
	end
	// Scoreboard: read data one cycle after the strobe, request edges counted per line.
	always @(posedge i_clk) begin
		if (rd_q) begin
			ev = q_rd.pop_front();
			`CHK(o_reg_rdata, ev)
		end
		if (eol) begin
			ec = q_req.pop_front();
			`CHK(cnt, ec)
			cnt = 4'h0;
		end else if (o_teletext_request && !req_q) cnt++;
		rd_q <= i_reg_read;
		req_q <= o_teletext_request;
	end
	initial begin
		{i_reg_write, i_reg_read, i_reg_addr, i_reg_wdata, i_m_system, i_field_rate_select, i_aux_clock} = '0;
		{i_aux_clock_output_select, i_field_sync, i_line_start, i_bit_slot, eol, rd_q, req_q} = '0;
		{i_odd_field, i_out_ready, cnt, r, num_errors, cmp_count} = {2'h3, 4'h0, 17'd94494, 64'h0};
		for (int s = 0; s < 2; s++) begin
			do_reset(s[0]);
			for (int a = 0; a < 8; a++) xfer(0, 1, 8'h76 + 8'(a), rv[s][a]);
			xfer(0, 0, 8'h00, 8'h00);
		end
		for (int a = 0; a < 6; a++) begin
			v = r[7:0];
			xfer(1, 0, 8'h76 + 8'(a), v);
			xfer(0, 1, 8'h76 + 8'(a), v);
		end
		$display("register test done");
		for (int p = 0; p < 3; p++) begin
			i_m_system = p == 1;
			xfer(1, 0, 8'h76, 8'h03);
			xfer(1, 0, 8'h77, 8'h06);
			xfer(1, 0, 8'h7C, {7'h00, p == 2});
			xfer(0, 0, 8'h00, 8'h00);
			for (int l = 0; l < 12; l++) line(l == 0, 2, (l >= (p == 2 ? 260 : p ? 7 : 4)
				&& l <= (p ? 9 : 6)) ? 4'h2 : 4'h0, 1);
			$display("window pass %0d done", p);
		end
		// Held protocol: one rising edge for the whole window, with two slots passing per line.
		xfer(1, 0, 8'h7C, 8'h20);
		xfer(0, 0, 8'h00, 8'h00);
		for (int l = 0; l < 8; l++) line(l == 0, 2, (l == 4) ? 4'h1 : 4'h0, 1);
		$display("held request test done");
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk) #1 i_field_rate_select = k[0];
			xfer(1, 0, 8'h7C, {k[1], 7'h00});
			xfer(0, 1, 8'h7C, {k[1], 7'h00});
			xfer(0, 0, 8'h00, 8'h00);
			repeat (4) @(posedge i_clk);
			`CHK(o_teletext_standard, k == 3 ? 2'h2 : {1'b0, k[0]})
		end
		@(posedge i_clk) #1 i_aux_clock_output_select = 1'b1;
		repeat (20) @(posedge i_clk);
		#1 i_aux_clock_output_select = 1'b0;
		$display("standard and pin test done");
		i_out_ready = 1'b0;
		line(1, 0, 4'h0, 1);
		for (int l = 1; l < 6; l++) line(0, 9, (l == 4) ? 4'h9 : (l == 5) ? 4'h7 : 4'h0, 1);
		line(0, 3, 4'h0, 1);
		`CHK(o_ttx_ready, 1'b0)
		i_out_ready = 1'b1;
		@(posedge i_clk);
		for (int b = 0; b < 16; b++) begin
			@(posedge i_clk);
			`CHK(o_out_valid, 1'b1)
			if (b > 0) `CHK(o_out_bit, !v[0])
			v[0] = o_out_bit;
		end
		repeat (40) @(posedge i_clk);
		`CHK(o_out_valid, 1'b0)
		$display("fifo test done");
		summarize();
	end
endmodule
